// ---- hprs_cfg.svh ----
// Constants of the host power and reset supervisor: offsets, fields, codes, times.
// Assumes one 100 MHz clock; included by the package and the top module.
//
// Operation
// - Config command takes mask and optional length; answers zero-length type 0x5C.
// - Reset and power invert bits make the asserted level high instead of low.
// - Auto polarity bit detects the asserted level of both lines.
// - Four function enables: blanking, keypad reset, keypad power-on, keypad power-off.
// - Optional pulse length in 1/32 s, 1 to 255; default one second.
// - Reset and power lines idle high-impedance, driven only during a pulse.
// - Sense high, confirm held 4 s: one-second reset pulse, message, self reboot.
// - After keypad reset pulse, commands are ignored until self reboot.
// - Sense low, confirm held 0.25 s: power pulse, message, self reboot.
// - Sense high, cancel held 4 s: power pulse, up to 5 s more while held.
// - Blanking enabled and sense low: screen and backlight off, keypad still scanned.
// - Blanked display leaves fan power settings untouched.
// - Sense rising with blanking enabled reboots the device as at power-up.
// - Watchdog command: timeout byte, zero disables, answers zero-length type 0x5D.
// - Unrefreshed watchdog resets the host with the keypad reset pulse.
// - Watchdog off at power-up and after it fires, until re-enabled.
// - Status query answers 15 bytes: byte 7 mask, byte 8 watchdog count.
`ifndef HPRS_CFG_SVH
`define HPRS_CFG_SVH

////////////////////////////////////////////////////////////////////////////////
`define HPRS_ADDR_CFG 4'h0
`define HPRS_ADDR_WDOG 4'h4
`define HPRS_ADDR_STAT 4'h8
`define HPRS_ADDR_RESP 4'hC

`define HPRS_BIT_AUTO 0
`define HPRS_BIT_RST_INV 1
`define HPRS_BIT_PWR_INV 2
`define HPRS_BIT_BLANK 4
`define HPRS_BIT_KP_RST 5
`define HPRS_BIT_KP_ON 6
`define HPRS_BIT_KP_OFF 7
`define HPRS_BIT_LEN_GIVEN 16

`define HPRS_RESP_CFG 8'h5C
`define HPRS_RESP_WDOG 8'h5D
`define HPRS_RESP_STAT 8'h5E
`define HPRS_LEN_STAT 8'h0F

`define HPRS_MASK_RESET 8'h00
`define HPRS_LEN_DEFAULT 8'h20

////////////////////////////////////////////////////////////////////////////////
`define HPRS_CLK_NS 10
`define HPRS_TICK_NS 31250000
`define HPRS_TICK_CYCLES (`HPRS_TICK_NS / `HPRS_CLK_NS)
`define HPRS_HOLD_LONG_S 4
`define HPRS_HOLD_SHORT_MS 250
`define HPRS_RST_PULSE_S 1
`define HPRS_EXTEND_S 5
`define HPRS_TICKS_PER_S 32
`define HPRS_HOLD_LONG_TK (`HPRS_HOLD_LONG_S * `HPRS_TICKS_PER_S)
`define HPRS_HOLD_SHORT_TK (`HPRS_HOLD_SHORT_MS * `HPRS_TICKS_PER_S / 1000)
`define HPRS_RST_PULSE_TK (`HPRS_RST_PULSE_S * `HPRS_TICKS_PER_S)
`define HPRS_EXTEND_TK (`HPRS_EXTEND_S * `HPRS_TICKS_PER_S)

`define HPRS_MSG_NONE 2'h0
`define HPRS_MSG_RESET 2'h1
`define HPRS_MSG_PWR_ON 2'h2
`define HPRS_MSG_PWR_OFF 2'h3

`endif

// ---- hprs_pkg.sv ----
// Types of the host power and reset supervisor.
// Assumes the constants header is on the include path.
`include "hprs_cfg.svh"

package hprs_pkg;

  typedef struct packed {
    logic len_given;
    logic [7:0] pulse_len;
    logic [7:0] mask;
  } hprs_cfg_t;

  typedef struct packed {
    logic [7:0] len;
    logic [7:0] kind;
  } hprs_resp_t;

  typedef enum logic [4:0] {
    HPRS_IDLE = 5'b00001,
    HPRS_RST_PULSE = 5'b00010,
    HPRS_PWR_PULSE = 5'b00100,
    HPRS_PWR_EXTEND = 5'b01000,
    HPRS_REBOOT = 5'b10000
  } hprs_state_t;

endpackage

// ---- hprs_top.sv ----
// Host power and reset supervisor with an AXI4-Lite register port.
// Assumes keys, sense and line levels come from pins and are synchronised here.
//
// The placing of the registers and the AXI4-Lite interface to the registers were decided locally.
`include "hprs_cfg.svh"

module hprs_top #(
  parameter int TICK_CYCLES = `HPRS_TICK_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [3:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [3:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic key_confirm_i,
  input wire logic key_cancel_i,
  input wire logic host_sense_i,
  input wire logic reset_line_i,
  output logic reset_line_o,
  output logic reset_line_oe,
  input wire logic power_line_i,
  output logic power_line_o,
  output logic power_line_oe,
  output logic blank_display_o,
  output logic [1:0] message_o,
  output logic self_reboot_o,
  output hprs_pkg::hprs_cfg_t cfg_o
);
  import hprs_pkg::*;

  function automatic logic hit_tk(input logic [7:0] cnt, input int lim);
    hit_tk = (cnt == 8'(lim));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: first stage read only by the second
  logic [4:0] sync1_ff, sync2_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_ff <= 5'h00;
      sync2_ff <= 5'h00;
    end else begin
      sync1_ff <= {power_line_i, reset_line_i, host_sense_i, key_cancel_i, key_confirm_i};
      sync2_ff <= sync1_ff;
    end
  end
  logic confirm, cancel, sense, rst_lvl, pwr_lvl;
  assign {pwr_lvl, rst_lvl, sense, cancel, confirm} = sync2_ff;

  ////////////////////////////////////////////////////////////////////////////
  // 1/32 s tick
  logic [31:0] tick_cnt_ff;
  logic tick_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_ff <= 32'h0;
      tick_ff <= 1'b0;
    end else if (tick_cnt_ff == 32'(TICK_CYCLES - 1)) begin
      tick_cnt_ff <= 32'h0;
      tick_ff <= 1'b1;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 32'h1;
      tick_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  hprs_cfg_t cfg_ff;
  hprs_resp_t resp_ff;
  hprs_state_t state_ff;
  logic lock_ff, wd_on_ff;
  logic [7:0] wd_cnt_ff, aw_addr_ff;
  logic [31:0] w_data_ff;
  logic aw_have_ff, w_have_ff;
  logic wr_go, cmd_ok, wr_map;
  logic [3:0] wstrb_ff;
  assign wr_go = aw_have_ff && w_have_ff && !bvalid;
  assign wr_map = aw_addr_ff[3:0] == `HPRS_ADDR_CFG || aw_addr_ff[3:0] == `HPRS_ADDR_WDOG
               || aw_addr_ff[3:0] == `HPRS_ADDR_STAT || aw_addr_ff[3:0] == `HPRS_ADDR_RESP;
  assign cmd_ok = wr_go && !lock_ff && wstrb_ff[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      aw_have_ff <= 1'b0;
      w_have_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_data_ff <= 32'h0;
      wstrb_ff <= 4'h0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
    end else begin
      if (awvalid && awready) begin
        aw_have_ff <= 1'b1;
        aw_addr_ff <= {4'h0, awaddr};
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        w_have_ff <= 1'b1;
        w_data_ff <= wdata;
        wstrb_ff <= wstrb;
        wready <= 1'b0;
      end
      if (wr_go) begin
        bvalid <= 1'b1;
        bresp <= wr_map ? 2'h0 : 2'h2;
        aw_have_ff <= 1'b0;
        w_have_ff <= 1'b0;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= 2'h0;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rresp <= 2'h0;
      case (araddr)
        `HPRS_ADDR_CFG: rdata <= 32'(cfg_ff);
        `HPRS_ADDR_WDOG: rdata <= {23'h0, wd_on_ff, wd_cnt_ff};
        `HPRS_ADDR_STAT: rdata <= {10'h0, lock_ff, state_ff, wd_cnt_ff, cfg_ff.mask};
        `HPRS_ADDR_RESP: rdata <= {16'h0, resp_ff};
        default: begin
          rdata <= 32'h0;
          rresp <= 2'h2;
        end
      endcase
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command execution and reply record
  logic wr_cfg, wr_wd, wr_stat;
  assign wr_cfg = cmd_ok && aw_addr_ff[3:0] == `HPRS_ADDR_CFG;
  assign wr_wd = cmd_ok && aw_addr_ff[3:0] == `HPRS_ADDR_WDOG;
  assign wr_stat = cmd_ok && aw_addr_ff[3:0] == `HPRS_ADDR_STAT;

  // Configuration survives a self reboot, as a stored boot state would
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_ff <= '{len_given: 1'b0, pulse_len: `HPRS_LEN_DEFAULT, mask: `HPRS_MASK_RESET};
    end else if (wr_cfg) begin
      cfg_ff.mask <= w_data_ff[7:0];
      cfg_ff.len_given <= w_data_ff[`HPRS_BIT_LEN_GIVEN] && wstrb_ff[1] && w_data_ff[15:8] != 8'h00;
      cfg_ff.pulse_len <= (w_data_ff[`HPRS_BIT_LEN_GIVEN] && wstrb_ff[1] && w_data_ff[15:8] != 8'h00)
                          ? w_data_ff[15:8] : `HPRS_LEN_DEFAULT;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      resp_ff <= '{len: 8'h00, kind: 8'h00};
    end else if (wr_cfg) begin
      resp_ff <= '{len: 8'h00, kind: `HPRS_RESP_CFG};
    end else if (wr_wd) begin
      resp_ff <= '{len: 8'h00, kind: `HPRS_RESP_WDOG};
    end else if (wr_stat) begin
      resp_ff <= '{len: `HPRS_LEN_STAT, kind: `HPRS_RESP_STAT};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Key hold timers, counted in ticks and cleared on release
  logic [7:0] conf_tk_ff, canc_tk_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn || !confirm) begin
      conf_tk_ff <= 8'h00;
    end else if (tick_ff && conf_tk_ff != 8'hFF) begin
      conf_tk_ff <= conf_tk_ff + 8'h01;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || !cancel) begin
      canc_tk_ff <= 8'h00;
    end else if (tick_ff && canc_tk_ff != 8'hFF) begin
      canc_tk_ff <= canc_tk_ff + 8'h01;
    end
  end

  // Trigger fires once, in the cycle the count reaches its threshold
  logic tk_edge_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) tk_edge_ff <= 1'b0;
    else tk_edge_ff <= tick_ff;
  end
  logic go_kp_rst, go_kp_on, go_kp_off, wd_fire;
  assign go_kp_rst = tk_edge_ff && cfg_ff.mask[`HPRS_BIT_KP_RST] && sense
                     && hit_tk(conf_tk_ff, `HPRS_HOLD_LONG_TK);
  assign go_kp_on = tk_edge_ff && cfg_ff.mask[`HPRS_BIT_KP_ON] && !sense
                    && hit_tk(conf_tk_ff, `HPRS_HOLD_SHORT_TK);
  assign go_kp_off = tk_edge_ff && cfg_ff.mask[`HPRS_BIT_KP_OFF] && sense
                     && hit_tk(canc_tk_ff, `HPRS_HOLD_LONG_TK);

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog: one-second count down while armed
  logic [7:0] wd_sub_ff;
  assign wd_fire = tk_edge_ff && wd_on_ff && wd_cnt_ff == 8'h01
                   && hit_tk(wd_sub_ff, `HPRS_TICKS_PER_S - 1);
  always_ff @(posedge aclk) begin
    if (!aresetn || state_ff == HPRS_REBOOT) begin
      wd_on_ff <= 1'b0;
      wd_cnt_ff <= 8'h00;
      wd_sub_ff <= 8'h00;
    end else if (wr_wd) begin
      wd_on_ff <= w_data_ff[7:0] != 8'h00;
      wd_cnt_ff <= w_data_ff[7:0];
      wd_sub_ff <= 8'h00;
    end else if (wd_fire) begin
      wd_on_ff <= 1'b0;
      wd_cnt_ff <= 8'h00;
      wd_sub_ff <= 8'h00;
    end else if (tk_edge_ff && wd_on_ff) begin
      if (hit_tk(wd_sub_ff, `HPRS_TICKS_PER_S - 1)) begin
        wd_sub_ff <= 8'h00;
        wd_cnt_ff <= wd_cnt_ff - 8'h01;
      end else begin
        wd_sub_ff <= wd_sub_ff + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pulse sequencer
  logic [7:0] pulse_tk_ff;
  logic kp_src_ff, reboot_after_ff, sense_q_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) sense_q_ff <= 1'b0;
    else sense_q_ff <= sense;
  end
  logic sense_rise;
  assign sense_rise = sense && !sense_q_ff && cfg_ff.mask[`HPRS_BIT_BLANK];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= HPRS_IDLE;
      pulse_tk_ff <= 8'h00;
      kp_src_ff <= 1'b0;
      reboot_after_ff <= 1'b0;
      lock_ff <= 1'b0;
      message_o <= `HPRS_MSG_NONE;
    end else begin
      case (state_ff)
        HPRS_IDLE: begin
          if (go_kp_rst || wd_fire) begin
            state_ff <= HPRS_RST_PULSE;
            pulse_tk_ff <= 8'(`HPRS_RST_PULSE_TK);
            kp_src_ff <= go_kp_rst;
            message_o <= go_kp_rst ? `HPRS_MSG_RESET : `HPRS_MSG_NONE;
          end else if (go_kp_on || go_kp_off) begin
            state_ff <= HPRS_PWR_PULSE;
            pulse_tk_ff <= cfg_ff.pulse_len;
            reboot_after_ff <= go_kp_on;
            message_o <= go_kp_on ? `HPRS_MSG_PWR_ON : `HPRS_MSG_PWR_OFF;
          end else if (sense_rise) begin
            state_ff <= HPRS_REBOOT;
          end
        end
        HPRS_RST_PULSE: begin
          if (tk_edge_ff) pulse_tk_ff <= pulse_tk_ff - 8'h01;
          if (tk_edge_ff && pulse_tk_ff == 8'h01) begin
            state_ff <= kp_src_ff ? HPRS_REBOOT : HPRS_IDLE;
            lock_ff <= kp_src_ff;
            message_o <= `HPRS_MSG_NONE;
          end
        end
        HPRS_PWR_PULSE: begin
          if (tk_edge_ff) pulse_tk_ff <= pulse_tk_ff - 8'h01;
          if (tk_edge_ff && pulse_tk_ff == 8'h01) begin
            if (!reboot_after_ff && cancel) begin
              state_ff <= HPRS_PWR_EXTEND;
              pulse_tk_ff <= 8'(`HPRS_EXTEND_TK);
            end else begin
              state_ff <= reboot_after_ff ? HPRS_REBOOT : HPRS_IDLE;
              message_o <= `HPRS_MSG_NONE;
            end
          end
        end
        HPRS_PWR_EXTEND: begin
          if (tk_edge_ff) pulse_tk_ff <= pulse_tk_ff - 8'h01;
          if (!cancel || (tk_edge_ff && pulse_tk_ff == 8'h01)) begin
            state_ff <= HPRS_IDLE;
            message_o <= `HPRS_MSG_NONE;
          end
        end
        HPRS_REBOOT: begin
          state_ff <= HPRS_IDLE;
          lock_ff <= 1'b0;
          reboot_after_ff <= 1'b0;
          kp_src_ff <= 1'b0;
        end
        default: state_ff <= HPRS_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line drivers; idle level is learned only while the line is released
  logic rst_idle_ff, pwr_idle_ff;
  logic rst_on, pwr_on, rst_act, pwr_act;
  logic [2:0] rst_oe_q_ff, pwr_oe_q_ff;
  // Synchroniser still shows the driven level for a few cycles after release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_oe_q_ff <= 3'h0;
      pwr_oe_q_ff <= 3'h0;
    end else begin
      rst_oe_q_ff <= {rst_oe_q_ff[1:0], reset_line_oe};
      pwr_oe_q_ff <= {pwr_oe_q_ff[1:0], power_line_oe};
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_idle_ff <= 1'b1;
      pwr_idle_ff <= 1'b1;
    end else begin
      if (!reset_line_oe && rst_oe_q_ff == 3'h0) rst_idle_ff <= rst_lvl;
      if (!power_line_oe && pwr_oe_q_ff == 3'h0) pwr_idle_ff <= pwr_lvl;
    end
  end
  assign rst_act = cfg_ff.mask[`HPRS_BIT_AUTO] ? !rst_idle_ff : cfg_ff.mask[`HPRS_BIT_RST_INV];
  assign pwr_act = cfg_ff.mask[`HPRS_BIT_AUTO] ? !pwr_idle_ff : cfg_ff.mask[`HPRS_BIT_PWR_INV];
  assign rst_on = state_ff == HPRS_RST_PULSE;
  assign pwr_on = state_ff == HPRS_PWR_PULSE || state_ff == HPRS_PWR_EXTEND;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reset_line_oe <= 1'b0;
      reset_line_o <= 1'b0;
      power_line_oe <= 1'b0;
      power_line_o <= 1'b0;
    end else begin
      reset_line_oe <= rst_on;
      reset_line_o <= rst_on ? rst_act : 1'b0;
      power_line_oe <= pwr_on;
      power_line_o <= pwr_on ? pwr_act : 1'b0;
    end
  end

  // Blanking only gates the display; fan drive lives elsewhere and is untouched
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      blank_display_o <= 1'b0;
      self_reboot_o <= 1'b0;
      cfg_o <= '0;
    end else begin
      blank_display_o <= cfg_ff.mask[`HPRS_BIT_BLANK] && !sense;
      self_reboot_o <= state_ff == HPRS_REBOOT;
      cfg_o <= cfg_ff;
    end
  end

endmodule

// ---- hprs_host_model.sv ----
// Host side of the supervisor: pulled-up control lines and a soft power switch.
// Assumes the bench may force the host state through set_req and set_val.
module hprs_host_model (
  input wire logic aclk,
  input wire logic reset_line_o,
  input wire logic reset_line_oe,
  input wire logic power_line_o,
  input wire logic power_line_oe,
  input wire logic set_req,
  input wire logic set_val,
  output logic reset_line_i,
  output logic power_line_i,
  output logic host_sense_o
);
  logic on_ff;
  logic pwr_seen_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Released lines float up to the host's pull-ups, never to a stale value
  assign reset_line_i = reset_line_oe ? reset_line_o : 1'b1;
  assign power_line_i = power_line_oe ? power_line_o : 1'b1;
  assign host_sense_o = on_ff;

  // Supply toggles at the end of each power pulse, as a soft power button
  always_ff @(posedge aclk) begin
    pwr_seen_ff <= power_line_oe;
    if (set_req) begin
      on_ff <= set_val;
    end else if (pwr_seen_ff && !power_line_oe) begin
      on_ff <= !on_ff;
    end
  end
endmodule

// ---- hprs_chk.sv ----
// Port checker of the supervisor.
// Assumes it is bound to hprs_top and sees only its ports.
module hprs_chk
  import hprs_pkg::*;
#(
  parameter int TICK_CYCLES = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awready,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic host_sense_i,
  input wire logic reset_line_o,
  input wire logic reset_line_oe,
  input wire logic power_line_o,
  input wire logic power_line_oe,
  input wire logic blank_display_o,
  input wire logic [1:0] message_o,
  input wire logic self_reboot_o,
  input wire hprs_pkg::hprs_cfg_t cfg_o
);
  // Run limits allow one tick of lag on top of the longest legal pulse
  localparam int RST_MAX = 33 * TICK_CYCLES + 2;
  localparam int PWR_MAX = 416 * TICK_CYCLES + 2;
  int rst_run_ff;
  int pwr_run_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) rst_run_ff <= 0;
    else rst_run_ff <= reset_line_oe ? rst_run_ff + 1 : 0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) pwr_run_ff <= 0;
    else pwr_run_ff <= power_line_oe ? pwr_run_ff + 1 : 0;
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_rst_level: assert property (reset_line_oe && !cfg_o.mask[0] |-> reset_line_o == cfg_o.mask[1])
    else $error("reset line driven at wrong level");
  a_pwr_level: assert property (power_line_oe && !cfg_o.mask[0] |-> power_line_o == cfg_o.mask[2])
    else $error("power line driven at wrong level");
  a_rst_len: assert property (rst_run_ff <= RST_MAX)
    else $error("reset pulse too long");
  a_pwr_len: assert property (pwr_run_ff <= PWR_MAX)
    else $error("power pulse too long");
  a_blank_host_off: assert property ((!host_sense_i && cfg_o.mask[4])[*5] |-> blank_display_o)
    else $error("display not blanked with host off");
  a_sense_reboot: assert property ($rose(host_sense_i) && cfg_o.mask[4] |-> ##[1:8] self_reboot_o)
    else $error("no reboot after sense rise");
  a_pwr_msg: assert property ($rose(power_line_oe) |-> ##[0:3] message_o inside {2'h2, 2'h3})
    else $error("no power message with power pulse");
  a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  a_r_after_ar: assert property (arvalid && arready |=> rvalid)
    else $error("read data late");

  c_rst_pulse: cover property ($rose(reset_line_oe));
  c_pwr_pulse: cover property ($rose(power_line_oe));
  c_reboot: cover property (self_reboot_o);
endmodule

bind hprs_top hprs_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.*);

// ---- testbench.sv ----
// Self-checking bench of the supervisor with a host model on its lines.
// Assumes a short tick parameter so that seconds pass in a few cycles.
module testbench;
  import hprs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TC = 4;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, set_req, set_val;
  logic awready, wready, bvalid, arready, rvalid, host_sense_i, key_confirm_i, key_cancel_i;
  logic reset_line_i, reset_line_o, reset_line_oe, power_line_i, power_line_o, power_line_oe;
  logic blank_display_o, self_reboot_o;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp, message_o, m;
  logic lvl;
  hprs_cfg_t cfg_o;
  int n_errors, samples_checked, boots, len, b;

  hprs_top #(.TICK_CYCLES(TC)) dut (.*);
  hprs_host_model host (.*, .host_sense_o(host_sense_i));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) if (self_reboot_o === 1'b1) boots++;

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rng(input int v, input int lo, input int hi);
    check({31'h0, v >= lo && v <= hi}, 32'h1);
  endtask
  task automatic tk(input int t);
    repeat (t * TC) @(posedge aclk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] dv, input logic [1:0] er);
    bit aw, w;
    int n;
    aw = 0; w = 0; n = 0;
    awaddr <= a; wdata <= dv; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (n < 200) begin
      @(posedge aclk);
      n++;
      if (bvalid && aw && w) break;
      if (awready && !aw) begin aw = 1; awvalid <= 1'b0; end
      if (wready && !w) begin w = 1; wvalid <= 1'b0; end
    end
    check({30'h0, bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] dv, input logic [1:0] er);
    bit ar;
    int n;
    ar = 0; n = 0;
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    while (n < 200) begin
      @(posedge aclk);
      n++;
      if (rvalid && ar) break;
      if (arready && !ar) begin ar = 1; arvalid <= 1'b0; end
    end
    dv = rdata;
    check({30'h0, rresp}, {30'h0, er});
  endtask
  task automatic set_host(input logic v);
    set_req <= 1'b1; set_val <= v;
    @(posedge aclk);
    set_req <= 1'b0;
  endtask
  // Waits for a pulse on one line, then times it and samples it four cycles in
  task automatic pulse(input bit p);
    int n;
    n = 0; len = 0;
    while ((p ? power_line_oe : reset_line_oe) !== 1'b1 && n < 3000) begin
      @(posedge aclk); n++;
    end
    while ((p ? power_line_oe : reset_line_oe) === 1'b1 && len < 3000) begin
      @(posedge aclk); len++;
      if (len == 4) begin lvl = p ? power_line_o : reset_line_o; m = message_o; end
    end
  endtask
  task automatic quiet(input int c);
    int hi;
    hi = 0;
    repeat (c) begin @(posedge aclk); if (power_line_oe !== 1'b0 || reset_line_oe !== 1'b0) hi++; end
    check(hi, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd(4'h0, d, 2'h0); check(d, 32'h0000_2000);
    rd(4'h4, d, 2'h0); check(d, 32'h0);
    rd(4'h2, d, 2'h2);
    check({30'h0, reset_line_oe, power_line_oe}, 32'h0);
  endtask
  task automatic t_config;
    wr(4'h0, 32'h0001_03F6, 2'h0);
    rd(4'h0, d, 2'h0); check(d, 32'h0001_03F6);
    rd(4'hC, d, 2'h0); check(d, 32'h0000_005C);
  endtask
  task automatic t_blank;
    set_host(1'b0); tk(2);
    check({31'h0, blank_display_o}, 32'h1);
    b = boots; set_host(1'b1); tk(2);
    check(boots - b, 32'h1);
    check({31'h0, blank_display_o}, 32'h0);
  endtask
  task automatic t_keys;
    set_host(1'b0);
    key_confirm_i <= 1'b1; tk(4); key_confirm_i <= 1'b0;
    quiet(20 * TC);
    key_confirm_i <= 1'b1; pulse(1); key_confirm_i <= 1'b0;
    rng(len, 3 * TC - 1, 4 * TC);
    check({31'h0, lvl}, 32'h1);
    check({30'h0, m}, 32'h2);
    tk(4); key_cancel_i <= 1'b1; pulse(1); key_cancel_i <= 1'b0;
    rng(len, 163 * TC - 1, 164 * TC);
    check({30'h0, m}, 32'h3);
    set_host(1'b1); tk(2);
    b = boots;
    key_confirm_i <= 1'b1; pulse(0); key_confirm_i <= 1'b0;
    rng(len, 32 * TC - 1, 33 * TC);
    check({31'h0, lvl}, 32'h1);
    check({30'h0, m}, 32'h1);
    tk(4);
    check({31'h0, boots > b}, 32'h1);
  endtask
  task automatic t_wdog;
    wr(4'h0, 32'h0000_0021, 2'h0);
    wr(4'h4, 32'h1, 2'h0);
    rd(4'hC, d, 2'h0); check(d, 32'h0000_005D);
    wr(4'h8, 32'h0, 2'h0);
    rd(4'hC, d, 2'h0); check(d, 32'h0000_0F5E);
    rd(4'h8, d, 2'h0); check(d[15:0], 32'h0121);
    pulse(0);
    rng(len, 32 * TC - 1, 33 * TC);
    check({31'h0, lvl}, 32'h0);
    rd(4'h4, d, 2'h0); check({31'h0, d[8]}, 32'h0);
    quiet(60 * TC);
    wr(4'h4, 32'h2, 2'h0);
    wr(4'h4, 32'h0, 2'h0);
    quiet(80 * TC);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    if (n_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge aclk);
    n_errors++;
    end_of_test();
  end

  initial begin
    aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
    rready = 1'b0; awaddr = 4'h0; araddr = 4'h0; wdata = 32'h0; wstrb = 4'hF;
    key_confirm_i = 1'b0; key_cancel_i = 1'b0; set_req = 1'b1; set_val = 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1; set_req <= 1'b0;
    @(posedge aclk);
    t_reset();
    t_config();
    t_blank();
    t_keys();
    t_wdog();
    end_of_test();
  end
endmodule
